// ---- shared/ptc_consts.svh ----
`ifndef PTC_CONSTS_SVH
`define PTC_CONSTS_SVH

// Register byte offsets
`define PTC_OFS_CONTROL      5'h00
`define PTC_OFS_PERIOD       5'h04
`define PTC_OFS_CAPTURE      5'h08
`define PTC_OFS_STATUS       5'h0c
`define PTC_OFS_CONFIG       5'h10

// Control, config and status field positions and reset values
`define PTC_CTL_MODE_LO      0
`define PTC_CTL_MODE_HI      1
`define PTC_CTL_CLK_LO       2
`define PTC_CTL_CLK_HI       3
`define PTC_CTL_START_LO     4
`define PTC_CTL_START_HI     5
`define PTC_CTL_OPT          6
`define PTC_CTL_RESET        8'h00
`define PTC_CFG_TAP          0
`define PTC_CFG_LOWSPD       1
`define PTC_CFG_RESET        2'h0
`define PTC_STS_RUN          16
`define PTC_STS_PIN          17

// Field encodings
`define PTC_MODE_BASE        2'h0
`define PTC_MODE_WINDOW      2'h1
`define PTC_MODE_PULSE       2'h2
`define PTC_START_STOP       2'h0
`define PTC_START_CMD        2'h1
`define PTC_START_RISE       2'h2
`define PTC_CLK_EXT          2'h3
`define PTC_CLK_DIV_SLOW     2'h0
`define PTC_CLK_DIV_MID      2'h1
`define PTC_CLK_DIV_FAST     2'h2

// Prescaler exponents (high_freq_clock periods) and low clock divider
`define PTC_DIV_EXP_SLOW     11
`define PTC_DIV_EXP_MID      7
`define PTC_DIV_EXP_FAST     3
`define PTC_FS_DIV_EXP       3

// Noise filter, in high_freq_clock periods
`define PTC_FILT_REJECT_CYC  4
`define PTC_FILT_ACCEPT_CYC  12
`define PTC_FILT_THRESH_CYC  ((`PTC_FILT_REJECT_CYC + `PTC_FILT_ACCEPT_CYC) / 2)

`endif

// ---- shared/ptc_pkg.sv ----
package ptc_pkg;

    typedef enum logic {
        PTC_HALTED,
        PTC_COUNTING
    } ptc_run_t;

endpackage : ptc_pkg

// ---- design/ptc_prescaler.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "ptc_consts.svh"

module ptc_prescaler (
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rstn,
    // Selection
    input  wire logic [1:0] i_clk_sel,
    input  wire logic       i_tap_sel,
    input  wire logic       i_low_speed,
    // Low-frequency clock pin
    input  wire logic       i_low_freq_clock,
    // Source tick
    output logic            o_tick
);

    logic [`PTC_DIV_EXP_SLOW-1:0] div_q;
    logic [`PTC_FS_DIV_EXP-1:0]   fs_div_q;
    logic [2:0]                   fs_sync_q;
    logic                         tick_q;
    logic                         tick_d;
    wire                          fs_edge = fs_sync_q[1] & ~fs_sync_q[2];
    wire                          tick_slow = &div_q[`PTC_DIV_EXP_SLOW-1:0];
    wire                          tick_mid = &div_q[`PTC_DIV_EXP_MID-1:0];
    wire                          tick_fast = &div_q[`PTC_DIV_EXP_FAST-1:0];
    wire                          tick_fs = fs_edge & (&fs_div_q);

    // In low-speed modes only the slowest code has a source
    always_comb begin
        tick_d = 1'b0;
        if (i_low_speed) begin
            tick_d = (i_clk_sel == `PTC_CLK_DIV_SLOW) & tick_fs;
        end else begin
            unique case (i_clk_sel)
                `PTC_CLK_DIV_SLOW: tick_d = i_tap_sel ? tick_fs : tick_slow;
                `PTC_CLK_DIV_MID:  tick_d = tick_mid;
                `PTC_CLK_DIV_FAST: tick_d = tick_fast;
                default:           tick_d = 1'b0;
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            div_q     <= '0;
            fs_div_q  <= '0;
            fs_sync_q <= 3'h0;
            tick_q    <= 1'b0;
        end else begin
            div_q     <= div_q + 1'b1;
            fs_sync_q <= {fs_sync_q[1:0], i_low_freq_clock};
            fs_div_q  <= fs_edge ? fs_div_q + 1'b1 : fs_div_q;
            tick_q    <= tick_d;
        end
    end

    assign o_tick = tick_q;

endmodule : ptc_prescaler
`default_nettype wire

// ---- design/ptc_in_filter.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "ptc_consts.svh"

module ptc_in_filter #(
    parameter int THRESH = `PTC_FILT_THRESH_CYC
) (
    // Clock and reset
    input  wire logic i_clk,
    input  wire logic i_rstn,
    // Control
    input  wire logic i_bypass,
    // Pin
    input  wire logic i_pin,
    // Filtered level and edges
    output logic      o_level,
    output logic      o_rise,
    output logic      o_fall
);

    logic [1:0] sync_q;
    logic [3:0] stable_q;
    logic       level_q;
    logic       rise_q;
    logic       fall_q;
    wire        differs = sync_q[1] != level_q;
    // Unless i_bypass, a level must hold THRESH samples; shorter glitches then never reach level_q
    wire        accept = i_bypass | (stable_q == 4'(THRESH - 1));
    wire        flip = differs & accept;

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            sync_q   <= 2'h0;
            stable_q <= 4'h0;
            level_q  <= 1'b0;
            rise_q   <= 1'b0;
            fall_q   <= 1'b0;
        end else begin
            sync_q   <= {sync_q[0], i_pin};
            stable_q <= (differs & !flip) ? stable_q + 1'b1 : 4'h0;
            level_q  <= flip ? sync_q[1] : level_q;
            rise_q   <= flip & sync_q[1];
            fall_q   <= flip & ~sync_q[1];
        end
    end

    assign o_level = level_q;
    assign o_rise  = rise_q;
    assign o_fall  = fall_q;

endmodule : ptc_in_filter
`default_nettype wire

// ---- design/ptc_timer_counter.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "ptc_consts.svh"

// Operation
// - Five modes chosen by operating mode select
// - Timer counts ticks, matches, clears, continues
// - Auto-capture copies count every source tick
// - Clock codes give fc/2^11, 2^7, 2^3
// - Trigger mode idles until selected edge
// - Trigger match clears, halts, raises request
// - Stop select: opposite edge clears, halts
// - No stop select: other edges ignored
// - Pin filter rejects short pulses, bypassable
// - Event mode counts pin edges, matches, clears
// - Event match checked on opposite edge
// - Window mode counts ticks gated by level
// - Pulse mode starts on trigger edge
// - Single-edge: opposite edge captures, clears, halts
// - Rising measures high, falling measures low
// - Compare value applies after upper byte
// - Stop mode forces start control off
module ptc_timer_counter #(
    parameter int CNT_W = 16
) (
    // Clock and reset
    input  wire logic        I_CLOCK,
    input  wire logic        I_RESETN,
    // Avalon-MM slave
    input  wire logic [4:0]  I_AVS_ADDRESS,
    input  wire logic        I_AVS_READ,
    input  wire logic        I_AVS_WRITE,
    input  wire logic [31:0] I_AVS_WRITEDATA,
    input  wire logic [3:0]  I_AVS_BYTEENABLE,
    output logic [31:0]      O_AVS_READDATA,
    output logic             O_AVS_WAITREQUEST,
    // Pins and system
    input  wire logic        I_COUNTER_INPUT_PIN,
    input  wire logic        I_LOW_FREQ_CLOCK,
    input  wire logic        I_STOP_MODE,
    // Request
    output logic             O_MATCH_INTERRUPT
);

    // Register state
    logic [7:0]       ctrl_q;
    logic [7:0]       ctrl_d;
    logic [1:0]       cfg_q;
    logic [CNT_W-1:0] cmp_stage_q;
    logic [CNT_W-1:0] cmp_act_q;
    logic             cmp_pend_q;
    logic             ack_q;
    logic [31:0]      rdata_q;
    logic             stop_q;

    // Counter state
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic [CNT_W-1:0] cap_q;
    logic [CNT_W-1:0] cap_d;
    ptc_pkg::ptc_run_t run_q;
    ptc_pkg::ptc_run_t run_d;
    logic             irq_q;
    logic             irq_d;

    // Pin and tick
    logic             pin_level;
    logic             pin_rise;
    logic             pin_fall;
    logic             tick_int;

    // Bus decode
    wire        req      = I_AVS_READ | I_AVS_WRITE;
    wire        wr_take  = I_AVS_WRITE & ack_q;
    wire        hit_ctl  = I_AVS_ADDRESS == `PTC_OFS_CONTROL;
    wire        hit_per  = I_AVS_ADDRESS == `PTC_OFS_PERIOD;
    wire        hit_cap  = I_AVS_ADDRESS == `PTC_OFS_CAPTURE;
    wire        hit_sts  = I_AVS_ADDRESS == `PTC_OFS_STATUS;
    wire        hit_cfg  = I_AVS_ADDRESS == `PTC_OFS_CONFIG;
    wire        wr_ctl   = wr_take & hit_ctl & I_AVS_BYTEENABLE[0];
    wire        wr_per_l = wr_take & hit_per & I_AVS_BYTEENABLE[0];
    wire        wr_per_h = wr_take & hit_per & I_AVS_BYTEENABLE[1];
    wire        wr_cfg   = wr_take & hit_cfg & I_AVS_BYTEENABLE[0];

    // Control fields
    wire [1:0]  mode      = ctrl_q[`PTC_CTL_MODE_HI:`PTC_CTL_MODE_LO];
    wire [1:0]  clk_sel   = ctrl_q[`PTC_CTL_CLK_HI:`PTC_CTL_CLK_LO];
    wire [1:0]  start_sel = ctrl_q[`PTC_CTL_START_HI:`PTC_CTL_START_LO];
    wire        opt_bit   = ctrl_q[`PTC_CTL_OPT];
    wire        tap_sel   = cfg_q[`PTC_CFG_TAP];
    wire        low_speed = cfg_q[`PTC_CFG_LOWSPD];

    // Mode decode; the bit 6 option means a different thing per mode
    wire        started   = start_sel != `PTC_START_STOP;
    wire        edge_sel  = start_sel[1];
    wire        ext_clk   = clk_sel == `PTC_CLK_EXT;
    wire        base_md   = mode == `PTC_MODE_BASE;
    wire        timer_md  = base_md & (start_sel == `PTC_START_CMD);
    wire        trig_md   = base_md & edge_sel & ~ext_clk;
    wire        event_md  = base_md & edge_sel & ext_clk;
    wire        window_md = (mode == `PTC_MODE_WINDOW) & edge_sel;
    wire        pulse_md  = (mode == `PTC_MODE_PULSE) & edge_sel;
    wire        auto_capture_enable = opt_bit;
    wire        trigger_stop_select = opt_bit;
    wire        capture_edge_select = opt_bit;

    // Rising code: trigger on rise; falling code: trigger on fall
    wire        falling_sel = start_sel[0];
    wire        trig_edge   = falling_sel ? pin_fall : pin_rise;
    wire        opp_edge    = falling_sel ? pin_rise : pin_fall;
    wire        gate_open   = falling_sel ? ~pin_level : pin_level;
    wire        ext_tick    = falling_sel ? pin_fall : pin_rise;
    wire        src_tick    = ext_clk ? ext_tick : tick_int;
    wire        match       = cnt_q == cmp_act_q;
    wire [CNT_W-1:0] cnt_inc = cnt_q + 1'b1;
    wire        cap_mode    = timer_md | event_md | window_md;

    // Stop mode entry wins over a software start in the same cycle
    wire        stop_entry  = I_STOP_MODE & ~stop_q;

    ptc_prescaler u_prescaler (
        .i_clk            (I_CLOCK),
        .i_rstn           (I_RESETN),
        .i_clk_sel        (clk_sel),
        .i_tap_sel        (tap_sel),
        .i_low_speed      (low_speed),
        .i_low_freq_clock (I_LOW_FREQ_CLOCK),
        .o_tick           (tick_int)
    );

    // Filter is off in low-speed modes, leaving only the synchroniser
    ptc_in_filter u_in_filter (
        .i_clk    (I_CLOCK),
        .i_rstn   (I_RESETN),
        .i_bypass (low_speed),
        .i_pin    (I_COUNTER_INPUT_PIN),
        .o_level  (pin_level),
        .o_rise   (pin_rise),
        .o_fall   (pin_fall)
    );

    always_comb begin
        ctrl_d = wr_ctl ? I_AVS_WRITEDATA[7:0] : ctrl_q;
        if (stop_entry) begin
            ctrl_d[`PTC_CTL_START_HI:`PTC_CTL_START_LO] = `PTC_START_STOP;
        end
    end

    // Counter next state
    always_comb begin
        cnt_d = cnt_q;
        cap_d = cap_q;
        run_d = run_q;
        irq_d = 1'b0;
        if (!started) begin
            cnt_d = '0;
            run_d = ptc_pkg::PTC_HALTED;
        end else if (timer_md || window_md) begin
            if (src_tick && (timer_md || gate_open)) begin
                if (match) begin
                    cnt_d = '0;
                    irq_d = 1'b1;
                end else begin
                    cnt_d = cnt_inc;
                end
            end
        end else if (event_md) begin
            if (opp_edge && match) begin
                cnt_d = '0;
                irq_d = 1'b1;
            end else if (trig_edge) begin
                cnt_d = cnt_inc;
            end
        end else if (trig_md) begin
            if (run_q == ptc_pkg::PTC_HALTED) begin
                if (trig_edge) begin
                    run_d = ptc_pkg::PTC_COUNTING;
                end
            end else if (opp_edge && trigger_stop_select) begin
                cnt_d = '0;
                run_d = ptc_pkg::PTC_HALTED;
            end else if (tick_int) begin
                // Trigger edges while counting fall through unused
                if (match) begin
                    cnt_d = '0;
                    run_d = ptc_pkg::PTC_HALTED;
                    irq_d = 1'b1;
                end else begin
                    cnt_d = cnt_inc;
                end
            end
        end else if (pulse_md) begin
            if (run_q == ptc_pkg::PTC_HALTED) begin
                if (trig_edge) begin
                    run_d = ptc_pkg::PTC_COUNTING;
                end
            end else if (opp_edge) begin
                cap_d = cnt_q;
                irq_d = 1'b1;
                if (capture_edge_select) begin
                    cnt_d = '0;
                    run_d = ptc_pkg::PTC_HALTED;
                end
            end else if (trig_edge && !capture_edge_select) begin
                cap_d = cnt_q;
                irq_d = 1'b1;
                cnt_d = '0;
            end else if (tick_int) begin
                cnt_d = cnt_inc;
            end
        end
        // Capture lags the count by one source tick, hence the read delay
        if (started && auto_capture_enable && cap_mode && src_tick) begin
            cap_d = cnt_q;
        end
    end

    // Bus: one wait state, read data latched before waitrequest drops
    always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            ack_q   <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            ack_q <= req & ~ack_q;
            if (I_AVS_READ && !ack_q) begin
                unique case (1'b1)
                    hit_ctl: rdata_q <= {24'h00_0000, ctrl_q};
                    hit_per: rdata_q <= {{(32-CNT_W){1'b0}}, cmp_act_q};
                    hit_cap: rdata_q <= {{(32-CNT_W){1'b0}}, cap_q};
                    hit_sts: rdata_q <= {14'h0000, pin_level, run_q == ptc_pkg::PTC_COUNTING, cnt_q};
                    hit_cfg: rdata_q <= {30'h0000_0000, cfg_q};
                    default: rdata_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            ctrl_q <= `PTC_CTL_RESET;
            cfg_q  <= `PTC_CFG_RESET;
            stop_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            cfg_q  <= wr_cfg ? I_AVS_WRITEDATA[1:0] : cfg_q;
            stop_q <= I_STOP_MODE;
        end
    end

    // Compare staging: the low byte alone never reaches the active value
    always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            cmp_stage_q <= '1;
            cmp_act_q   <= '1;
            cmp_pend_q  <= 1'b0;
        end else begin
            if (wr_per_l) begin
                cmp_stage_q[7:0] <= I_AVS_WRITEDATA[7:0];
            end
            if (wr_per_h) begin
                cmp_stage_q[CNT_W-1:8] <= I_AVS_WRITEDATA[CNT_W-1:8];
            end
            if (wr_per_h) begin
                cmp_pend_q <= 1'b1;
            end else if (cmp_pend_q && src_tick) begin
                cmp_pend_q <= 1'b0;
                cmp_act_q  <= cmp_stage_q;
            end
        end
    end

    always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            cnt_q <= '0;
            cap_q <= '0;
            run_q <= ptc_pkg::PTC_HALTED;
            irq_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            cap_q <= cap_d;
            run_q <= run_d;
            irq_q <= irq_d;
        end
    end

    assign O_AVS_READDATA    = rdata_q;
    assign O_AVS_WAITREQUEST = req & ~ack_q;
    assign O_MATCH_INTERRUPT = irq_q;

endmodule : ptc_timer_counter
`default_nettype wire

// ---- test/ptc_timer_counter_chk.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "ptc_consts.svh"

module ptc_timer_counter_chk (
    // Clock and reset
    input  wire logic        I_CLOCK,
    input  wire logic        I_RESETN,
    // Register bus
    input  wire logic [4:0]  I_AVS_ADDRESS,
    input  wire logic        I_AVS_READ,
    input  wire logic        I_AVS_WRITE,
    input  wire logic [31:0] O_AVS_READDATA,
    input  wire logic        O_AVS_WAITREQUEST,
    // System and request
    input  wire logic        I_STOP_MODE,
    input  wire logic        O_MATCH_INTERRUPT
);
    default clocking cb @(posedge I_CLOCK);
    endclocking
    default disable iff (!I_RESETN);

    wire logic req    = I_AVS_READ | I_AVS_WRITE;
    wire logic rd_ack = I_AVS_READ & ~O_AVS_WAITREQUEST;

    sequence s_req_start;
        $rose(req);
    endsequence
    sequence s_one_wait;
        O_AVS_WAITREQUEST ##1 !O_AVS_WAITREQUEST;
    endsequence

    AST_WAIT_ONE: assert property (s_req_start |-> s_one_wait)
        else $error("waitrequest not one cycle");
    AST_IDLE_NOWAIT: assert property (!req |-> !O_AVS_WAITREQUEST)
        else $error("waitrequest while idle");
    AST_ACK_ONCE: assert property (req && !O_AVS_WAITREQUEST |=> O_AVS_WAITREQUEST || !req)
        else $error("second accept without wait state");
    AST_RD_STABLE: assert property ($changed(O_AVS_READDATA) |-> $past(I_AVS_READ))
        else $error("readdata moved without read");
    AST_UNMAPPED_ZERO: assert property (rd_ack && I_AVS_ADDRESS > `PTC_OFS_CONFIG |-> O_AVS_READDATA == 32'h0)
        else $error("unmapped read not zero");
    AST_DATA_WIDTH: assert property (
        rd_ack && (I_AVS_ADDRESS == `PTC_OFS_PERIOD || I_AVS_ADDRESS == `PTC_OFS_CAPTURE)
        |-> O_AVS_READDATA[31:16] == 16'h0)
        else $error("wide compare or capture value");
    AST_IRQ_PULSE: assert property (O_MATCH_INTERRUPT |=> !O_MATCH_INTERRUPT)
        else $error("interrupt longer than one cycle");
    AST_STOP_QUIET: assert property (I_STOP_MODE [*3] |-> !O_MATCH_INTERRUPT)
        else $error("interrupt during stop mode");
endmodule : ptc_timer_counter_chk

bind ptc_timer_counter ptc_timer_counter_chk i_chk (
    .I_CLOCK(I_CLOCK), .I_RESETN(I_RESETN), .I_AVS_ADDRESS(I_AVS_ADDRESS), .I_AVS_READ(I_AVS_READ),
    .I_AVS_WRITE(I_AVS_WRITE), .O_AVS_READDATA(O_AVS_READDATA), .O_AVS_WAITREQUEST(O_AVS_WAITREQUEST),
    .I_STOP_MODE(I_STOP_MODE), .O_MATCH_INTERRUPT(O_MATCH_INTERRUPT));

`default_nettype wire

// ---- test/ptc_pulse_src.sv ----
`timescale 1ns/1ns
`default_nettype none

module ptc_pulse_src (
    // Clock
    input  wire logic i_clk,
    // Pin
    output var logic  o_pin
);
    initial o_pin = 1'b0;

    // Levels under eight cycles only where a test wants rejection
    task automatic hold(input logic lvl, input int cyc);
        o_pin <= lvl;
        repeat (cyc) @(posedge i_clk);
    endtask : hold
endmodule : ptc_pulse_src

`default_nettype wire

// ---- test/tb.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "ptc_consts.svh"
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin miscompares++; $display("ERROR %0t: mismatch line %0d", $time, `__LINE__); end end

module tb;
    logic        clk;
    logic        rstn;
    logic [4:0]  addr;
    logic        rd;
    logic        wr;
    logic [31:0] wdata;
    logic [3:0]  be;
    logic [31:0] rdata;
    logic [31:0] q;
    logic        waitreq;
    wire logic   pin;
    logic [2:0]  lf_div;
    logic        stop;
    logic        irq;
    int          irq_cnt;
    int          c;
    int          miscompares;
    int          n_compared;

    ptc_timer_counter i_ptc_timer_counter (
        .I_CLOCK(clk), .I_RESETN(rstn), .I_AVS_ADDRESS(addr), .I_AVS_READ(rd), .I_AVS_WRITE(wr),
        .I_AVS_WRITEDATA(wdata), .I_AVS_BYTEENABLE(be), .O_AVS_READDATA(rdata), .O_AVS_WAITREQUEST(waitreq),
        .I_COUNTER_INPUT_PIN(pin), .I_LOW_FREQ_CLOCK(lf_div[2]), .I_STOP_MODE(stop), .O_MATCH_INTERRUPT(irq));
    ptc_pulse_src i_ptc_pulse_src (.i_clk(clk), .o_pin(pin));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    always @(posedge clk) begin
        lf_div <= lf_div + 3'h1;
        if (irq === 1'b1) irq_cnt <= irq_cnt + 1;
    end

    task automatic summarize();
        $display("Compared %0d, mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : summarize

    // Request held until the rising edge that samples waitrequest low
    task automatic xfer(input logic w, input logic [4:0] a, input logic [31:0] d, input logic [3:0] b);
        int n;
        addr <= a;
        wdata <= d;
        be <= b;
        wr <= w;
        rd <= ~w;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (waitreq !== 1'b0 && n < 64);
        q = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
        // Idle edge, so a following call never re-raises a strobe in this step
        @(posedge clk);
        if (n >= 64) begin
            miscompares++;
            summarize();
        end
    endtask : xfer

    task automatic wait_irq(input int max);
        int c0;
        c0 = irq_cnt;
        c = 0;
        do begin
            @(posedge clk);
            c++;
        end while (irq_cnt == c0 && c < max);
        if (irq_cnt == c0) c = -1;
    endtask : wait_irq

    task automatic setup(input logic [7:0] ctl, input logic [15:0] per);
        xfer(1'b1, `PTC_OFS_CONTROL, {24'h0, ctl & 8'hcf}, 4'h1);
        xfer(1'b1, `PTC_OFS_PERIOD, {16'h0, per}, 4'h3);
        repeat (20) @(posedge clk);
        xfer(1'b1, `PTC_OFS_CONTROL, {24'h0, ctl}, 4'h1);
    endtask : setup

    task automatic t_regs();
        xfer(1'b0, `PTC_OFS_PERIOD, 32'h0, 4'hf);
        `CHK(q, 32'h0000ffff)
        xfer(1'b1, `PTC_OFS_CAPTURE, 32'h1234, 4'hf);
        xfer(1'b0, `PTC_OFS_CAPTURE, 32'h0, 4'hf);
        `CHK(q, 32'h0)
        xfer(1'b1, 5'h14, 32'hffffffff, 4'hf);
        xfer(1'b0, 5'h14, 32'h0, 4'hf);
        `CHK(q, 32'h0)
        xfer(1'b1, `PTC_OFS_CONFIG, 32'h3, 4'hf);
        xfer(1'b0, `PTC_OFS_CONFIG, 32'h0, 4'hf);
        `CHK(q, 32'h3)
        xfer(1'b1, `PTC_OFS_CONFIG, 32'h0, 4'hf);
        xfer(1'b1, `PTC_OFS_CONTROL, 32'h58, 4'h1);
        xfer(1'b1, `PTC_OFS_PERIOD, 32'h5, 4'h1);
        repeat (40) @(posedge clk);
        xfer(1'b0, `PTC_OFS_PERIOD, 32'h0, 4'hf);
        `CHK(q, 32'h0000ffff)
        $display("done: registers");
    endtask : t_regs

    task automatic t_timer();
        int exps[3] = '{`PTC_DIV_EXP_SLOW, `PTC_DIV_EXP_MID, `PTC_DIV_EXP_FAST};
        for (int k = 0; k < 3; k++) begin
            setup({4'h5, k[1:0], 2'h0}, 16'h0001);
            repeat (3) wait_irq(9000);
            `CHK(c, 2 << exps[k])
            xfer(1'b0, `PTC_OFS_CAPTURE, 32'h0, 4'hf);
            `CHK(q[31:1], 31'h0)
        end
        $display("done: timer");
    endtask : t_timer

    task automatic t_trigger();
        logic opt[4] = '{1'b0, 1'b0, 1'b1, 1'b0};
        int   wid[4] = '{4, 12, 20, 20};
        logic hit[4] = '{1'b0, 1'b1, 1'b0, 1'b1};
        for (int k = 0; k < 4; k++) begin
            setup({1'b0, opt[k], 6'h28}, 16'h0005);
            wait_irq(100);
            `CHK(c, -1)
            i_ptc_pulse_src.hold(1'b1, wid[k]);
            i_ptc_pulse_src.hold(1'b0, 8);
            wait_irq(300);
            `CHK(c != -1, hit[k])
            wait_irq(200);
            `CHK(c, -1)
            xfer(1'b0, `PTC_OFS_STATUS, 32'h0, 4'hf);
            `CHK(q[17:0], 18'h0)
        end
        $display("done: trigger");
    endtask : t_trigger

    task automatic t_event();
        int c0;
        setup(8'h2c, 16'h0002);
        for (int k = 1; k <= 6; k++) begin
            c0 = irq_cnt;
            i_ptc_pulse_src.hold(1'b1, 12);
            `CHK(irq_cnt, c0)
            i_ptc_pulse_src.hold(1'b0, 24);
            `CHK(irq_cnt - c0, (k % 2 == 0) ? 1 : 0)
        end
        $display("done: event");
    endtask : t_event

    task automatic t_window();
        setup(8'h29, 16'h0003);
        wait_irq(200);
        `CHK(c, -1)
        i_ptc_pulse_src.hold(1'b1, 1);
        wait_irq(100);
        wait_irq(100);
        `CHK(c, 4 << `PTC_DIV_EXP_FAST)
        i_ptc_pulse_src.hold(1'b0, 40);
        wait_irq(200);
        `CHK(c, -1)
        $display("done: window");
    endtask : t_window

    task automatic t_pulse();
        int c0;
        for (int k = 0; k < 2; k++) begin
            setup(k ? 8'h7a : 8'h6a, 16'hffff);
            i_ptc_pulse_src.hold(k[0], 40);
            c0 = irq_cnt;
            i_ptc_pulse_src.hold(~k[0], 80);
            i_ptc_pulse_src.hold(k[0], 40);
            `CHK(irq_cnt - c0, 1)
            xfer(1'b0, `PTC_OFS_CAPTURE, 32'h0, 4'hf);
            `CHK(q >= 32'd9 && q <= 32'd11, 1'b1)
            xfer(1'b0, `PTC_OFS_STATUS, 32'h0, 4'hf);
            `CHK(q[16], 1'b0)
        end
        i_ptc_pulse_src.hold(1'b0, 40);
        $display("done: pulse");
    endtask : t_pulse

    task automatic t_stop();
        setup(8'h58, 16'h0001);
        wait_irq(100);
        stop <= 1'b1;
        repeat (3) @(posedge clk);
        wait_irq(200);
        `CHK(c, -1)
        xfer(1'b0, `PTC_OFS_CONTROL, 32'h0, 4'hf);
        `CHK(q[6:0], 7'h48)
        stop <= 1'b0;
        wait_irq(200);
        `CHK(c, -1)
        $display("done: stop");
    endtask : t_stop

    // Low clock source: the bench divides I_CLOCK by eight for it
    task automatic t_slow();
        xfer(1'b1, `PTC_OFS_CONFIG, 32'h1, 4'h1);
        setup(8'h50, 16'h0001);
        repeat (2) wait_irq(400);
        `CHK(c, 2 << (`PTC_FS_DIV_EXP + 3))
        xfer(1'b1, `PTC_OFS_CONFIG, 32'h2, 4'h1);
        setup(8'h54, 16'h0001);
        wait_irq(400);
        `CHK(c, -1)
        xfer(1'b1, `PTC_OFS_CONFIG, 32'h0, 4'h1);
        $display("done: low clock");
    endtask : t_slow

    initial begin
        rstn = 1'b0;
        addr = 5'h0;
        rd = 1'b0;
        wr = 1'b0;
        wdata = 32'h0;
        be = 4'h0;
        stop = 1'b0;
        lf_div = 3'h0;
        irq_cnt = 0;
        miscompares = 0;
        n_compared = 0;
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        t_regs();
        t_timer();
        t_trigger();
        t_event();
        t_window();
        t_pulse();
        t_stop();
        t_slow();
        summarize();
    end
endmodule : tb

`default_nettype wire
